/* File: logic/srf_cfg.svh */
// Register map, field positions, reset values and command codes of the refresh controller
`ifndef SRF_CFG_SVH
`define SRF_CFG_SVH
`define SRF_OFS_MCR       2'h0
`define SRF_OFS_REFRESH_TIMER_CTRL_REG     2'h1
`define SRF_OFS_CNT       2'h2
`define SRF_OFS_CMP       2'h3
`define SRF_WIN_BIT       15
`define SRF_BIT_RFEN      0
`define SRF_BIT_REFRESH_MODE_SELECT     1
`define SRF_BIT_TRP       2
`define SRF_RAS_LO        4
`define SRF_RAS_HI        6
`define SRF_CKS_HI        2
`define SRF_BIT_PEND      8
`define SRF_BIT_SREF      9
`define SRF_BIT_MRSP      10
`define SRF_STRB_LO_HALF  4'h3
`define SRF_STRB_HI_HALF  4'hc
`define SRF_CMD_NOP       4'h7
`define SRF_CMD_PRECHARGE_ALL_CMD      4'h2
`define SRF_CMD_REF       4'h1
`define SRF_CMD_MRS       4'h0
`define SRF_A10_BIT       10
`define SRF_CNT_RST       8'h00
`define SRF_CMP_RST       8'hff
`define SRF_ONE4          4'h1
`define SRF_TWO4          4'h2
`endif

/* File: logic/srf_pkg.sv */
// Types for the synchronous DRAM refresh and initialisation controller
package srf_pkg;
  typedef enum logic [2:0] {S_IDLE, S_PRECHARGE_ALL_CMD, S_PWAIT, S_REF, S_MRS, S_SREF, S_LOCK} srf_state_t;
  typedef enum logic [1:0] {OP_REF, OP_MRS, OP_SREF} srf_op_t;
  typedef struct packed {
    srf_state_t  st;
    srf_op_t     op;
    logic [3:0]  lock;
    logic        rfen;
    logic        refresh_mode_select;
    logic        precharge_wait_setting;
    logic [2:0]  ras;
    logic [2:0]  cks;
    logic [7:0]  cnt;
    logic [7:0]  cmp;
    logic [11:0] presc;
    logic        pend;
    logic        mrs_pend;
    logic [14:0] mode_x;
    logic [3:0]  cmd;
    logic        cke;
    logic [14:0] addr;
    logic        grant;
    logic        busy;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } srf_regs_t;
endpackage

/* File: logic/srf_ctrl.sv */
// Refresh, self-refresh and mode-register sequencer for synchronous DRAM with APB registers
//
// Notes on behaviour
// - Refresh enabled, mode zero: periodic auto-refresh.
// - Enable and mode both one: self-refresh.
// - Counter counts up once clock selected.
// - Match raises request, clears counter, resumes.
// - Auto-refresh: precharge-all, then refresh command.
// - After refresh, no command for delay+2.
// - Precharge wait set inserts one NOP.
// - Manual reset freezes counter, no requests.
// - Self-refresh drives clock enable low, no access.
// - Mode cleared ends self-refresh; delay+1 lockout.
// - Auto-refresh resumes after self-refresh if enabled.
// - Manual reset does not end self-refresh.
// - Refresh waits for bus cycle or bus regain.
// - New match replaces pending request; one held.
// - Arbitration not granted during self-refresh.
// - Window word write puts offset on address.
// - Mode write: precharge-all, optional idle, mode set.
// - Outputs on rising edge, data on falling.
//
// Local design decisions: the APB register port and the register addresses.
`include "srf_cfg.svh"
module srf_ctrl (
  // Clock and resets
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        manual_rst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [15:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic             pready_out,
  output logic [31:0]      prdata_out,
  output logic             pslverr_out,
  // Bus cycle and arbitration
  input  wire logic        bus_busy_in,
  input  wire logic        bus_released_in,
  input  wire logic        bus_arb_req_in,
  output logic             bus_grant_out,
  output logic             refresh_req_out,
  output logic             access_hold_out,
  // SDRAM side
  input  wire logic [15:0] sdram_dq_in,
  output logic [3:0]       sdram_cmd_out,
  output logic             sdram_cke_out,
  output logic [14:0]      sdram_addr_out,
  output logic [15:0]      rd_capture_out
);

  srf_pkg::srf_regs_t r;
  srf_pkg::srf_regs_t n;
  logic               apb_setup;
  logic               apb_wr;
  logic               is_reg;
  logic               is_win;
  logic               half_strb;
  logic               match;
  logic               can_go;
  logic               sref_req;

  // Word index of a register inside the control page
  function automatic logic [1:0] reg_idx(input logic [15:0] a);
    reg_idx = a[3:2];
  endfunction

  // Divider tap of the refresh clock; code zero stops the counter
  function automatic logic sel_tick(input logic [2:0] cks, input logic [11:0] p);
    logic [11:0] mask;
    mask = ~(12'hfff << {cks, 1'b0});
    sel_tick = (cks != 3'h0) && ((p & mask) == mask);
  endfunction

  // Next-state logic for every register of the block except the read capture
  always_comb begin
    n         = r;
    apb_setup = psel_in && !penable_in;
    apb_wr    = psel_in && penable_in && pwrite_in && r.pready && !r.pslverr;
    is_win    = paddr_in[`SRF_WIN_BIT];
    is_reg    = !is_win && (paddr_in[14:4] == 11'h000) && (paddr_in[1:0] == 2'h0);
    half_strb = (pstrb_in == `SRF_STRB_LO_HALF) || (pstrb_in == `SRF_STRB_HI_HALF);
    sref_req  = r.rfen && r.refresh_mode_select;
    // APB: answer one cycle after setup
    n.pready  = apb_setup;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (apb_setup) begin
      n.pslverr = !is_reg && !(is_win && pwrite_in && half_strb);
      if (is_reg && !pwrite_in) begin
        unique case (reg_idx(paddr_in))
          `SRF_OFS_MCR: begin
            n.prdata[`SRF_BIT_RFEN]              = r.rfen;
            n.prdata[`SRF_BIT_REFRESH_MODE_SELECT]             = r.refresh_mode_select;
            n.prdata[`SRF_BIT_TRP]               = r.precharge_wait_setting;
            n.prdata[`SRF_RAS_HI:`SRF_RAS_LO]    = r.ras;
          end
          `SRF_OFS_REFRESH_TIMER_CTRL_REG: begin
            n.prdata[`SRF_CKS_HI:0]              = r.cks;
            n.prdata[`SRF_BIT_PEND]              = r.pend;
            n.prdata[`SRF_BIT_SREF]              = (r.st == srf_pkg::S_SREF);
            n.prdata[`SRF_BIT_MRSP]              = r.mrs_pend;
          end
          `SRF_OFS_CNT: n.prdata[7:0] = r.cnt;
          `SRF_OFS_CMP: n.prdata[7:0] = r.cmp;
        endcase
      end
    end
    // Interval counter and compare
    n.presc = r.presc + 12'h001;
    match   = (r.cks != 3'h0) && !manual_rst_in && (r.cnt == r.cmp);
    if (match) begin
      n.cnt  = `SRF_CNT_RST;
      n.pend = 1'b1;
    end else if (sel_tick(r.cks, r.presc) && !manual_rst_in) begin
      n.cnt = r.cnt + 8'h01;
    end
    // Register writes
    if (apb_wr && is_reg) begin
      unique case (reg_idx(paddr_in))
        `SRF_OFS_MCR: begin
          n.rfen  = pwdata_in[`SRF_BIT_RFEN];
          n.refresh_mode_select = pwdata_in[`SRF_BIT_REFRESH_MODE_SELECT];
          n.precharge_wait_setting   = pwdata_in[`SRF_BIT_TRP];
          n.ras   = pwdata_in[`SRF_RAS_HI:`SRF_RAS_LO];
        end
        `SRF_OFS_REFRESH_TIMER_CTRL_REG: n.cks = pwdata_in[`SRF_CKS_HI:0];
        `SRF_OFS_CNT:   n.cnt = pwdata_in[7:0];
        `SRF_OFS_CMP:   n.cmp = pwdata_in[7:0];
      endcase
    end
    // Mode window write: offset becomes the mode value, data ignored
    if (apb_wr && is_win) begin
      n.mrs_pend = 1'b1;
      n.mode_x   = paddr_in[14:0];
    end
    // Command sequencer
    can_go = !bus_busy_in && !bus_released_in && !r.grant;
    n.cmd  = `SRF_CMD_NOP;
    n.addr = 15'h0000;
    unique case (r.st)
      srf_pkg::S_IDLE: begin
        if (can_go && sref_req) begin
          n.op = srf_pkg::OP_SREF;
          n.st = srf_pkg::S_PRECHARGE_ALL_CMD;
        end else if (can_go && r.pend && r.rfen) begin
          n.op   = srf_pkg::OP_REF;
          n.st   = srf_pkg::S_PRECHARGE_ALL_CMD;
          n.pend = match;
        end else if (can_go && r.mrs_pend) begin
          n.op       = srf_pkg::OP_MRS;
          n.st       = srf_pkg::S_PRECHARGE_ALL_CMD;
          n.mrs_pend = apb_wr && is_win;
        end
        if (n.st == srf_pkg::S_PRECHARGE_ALL_CMD) begin
          n.cmd                = `SRF_CMD_PRECHARGE_ALL_CMD;
          n.addr[`SRF_A10_BIT] = 1'b1;
        end
      end
      srf_pkg::S_PRECHARGE_ALL_CMD, srf_pkg::S_PWAIT: begin
        if (r.st == srf_pkg::S_PRECHARGE_ALL_CMD && r.precharge_wait_setting) begin
          n.st = srf_pkg::S_PWAIT;
        end else begin
          unique case (r.op)
            srf_pkg::OP_REF: begin
              n.st  = srf_pkg::S_REF;
              n.cmd = `SRF_CMD_REF;
            end
            srf_pkg::OP_MRS: begin
              n.st   = srf_pkg::S_MRS;
              n.cmd  = `SRF_CMD_MRS;
              n.addr = r.mode_x;
            end
            default: begin
              n.st  = srf_pkg::S_SREF;
              n.cmd = `SRF_CMD_REF;
              n.cke = 1'b0;
            end
          endcase
        end
      end
      srf_pkg::S_REF: begin
        n.st   = srf_pkg::S_LOCK;
        n.lock = {1'b0, r.ras} + `SRF_ONE4;
      end
      srf_pkg::S_MRS: n.st = srf_pkg::S_IDLE;
      srf_pkg::S_SREF: begin
        if (!r.refresh_mode_select) begin
          n.cke  = 1'b1;
          n.st   = srf_pkg::S_LOCK;
          n.lock = {1'b0, r.ras};
        end
      end
      srf_pkg::S_LOCK: begin
        if (r.lock == 4'h0) begin
          n.st = srf_pkg::S_IDLE;
        end else begin
          n.lock = r.lock - `SRF_ONE4;
        end
      end
      default: n.st = srf_pkg::S_IDLE; // Unused code falls back to idle
    endcase
    // Arbitration: hold off while refresh work waits or self-refresh runs
    n.grant = bus_arb_req_in && (r.grant || (r.st == srf_pkg::S_IDLE && n.st == srf_pkg::S_IDLE &&
              !r.pend && !r.mrs_pend && !sref_req));
    n.busy  = (n.st != srf_pkg::S_IDLE) || n.pend;
  end

  // State register; power-on reset leaves self-refresh, as does clearing mode select
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r       <= '0;
      r.st    <= srf_pkg::S_IDLE;
      r.op    <= srf_pkg::OP_REF;
      r.cmp   <= `SRF_CMP_RST;
      r.cmd   <= `SRF_CMD_NOP;
      r.cke   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Read data taken on the falling edge
  always_ff @(negedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_capture_out <= 16'h0000;
    end else begin
      rd_capture_out <= sdram_dq_in;
    end
  end

  // Outputs straight from flops
  assign pready_out      = r.pready;
  assign prdata_out      = r.prdata;
  assign pslverr_out     = r.pslverr;
  assign bus_grant_out   = r.grant;
  assign refresh_req_out = r.pend;
  assign access_hold_out = r.busy;
  assign sdram_cmd_out   = r.cmd;
  assign sdram_cke_out   = r.cke;
  assign sdram_addr_out  = r.addr;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // Sequencer checks
  precharge_all_cmd_then_ref_a: assert property ((r.st == srf_pkg::S_PRECHARGE_ALL_CMD) && (r.op == srf_pkg::OP_REF) && !r.precharge_wait_setting
    |=> (sdram_cmd_out == `SRF_CMD_REF)) else $error("refresh did not follow precharge-all");
  trp_nop_a: assert property ((r.st == srf_pkg::S_PRECHARGE_ALL_CMD) && r.precharge_wait_setting
    |=> (sdram_cmd_out == `SRF_CMD_NOP) ##1 (sdram_cmd_out != `SRF_CMD_NOP)) else $error("wait slot wrong");
  ref_lock_a: assert property ((r.st == srf_pkg::S_REF)
    |=> (r.st == srf_pkg::S_LOCK) && (r.lock == {1'b0, $past(r.ras)} + `SRF_ONE4)) else $error("lock length wrong");
  lock_quiet_a: assert property ((r.st == srf_pkg::S_LOCK) |-> (sdram_cmd_out == `SRF_CMD_NOP))
    else $error("command during lockout");
  sref_cke_a: assert property ((r.st == srf_pkg::S_SREF) |-> !sdram_cke_out)
    else $error("clock enable high in self-refresh");
  sref_exit_a: assert property ((r.st == srf_pkg::S_SREF) && !r.refresh_mode_select
    |=> sdram_cke_out && (r.st == srf_pkg::S_LOCK) && (r.lock == {1'b0, r.ras})) else $error("bad exit");
  mrst_freeze_a: assert property (manual_rst_in && !apb_wr |=> $stable(r.cnt))
    else $error("counter moved in manual reset");
  match_clear_a: assert property (match && !apb_wr |=> (r.cnt == `SRF_CNT_RST) && r.pend)
    else $error("match did not clear counter");
  sref_grant_a: assert property ((r.st == srf_pkg::S_SREF) |=> !bus_grant_out || $past(r.grant))
    else $error("grant during self-refresh");
  bus_wait_a: assert property ((r.st == srf_pkg::S_IDLE) && (bus_busy_in || bus_released_in)
    |=> (r.st == srf_pkg::S_IDLE)) else $error("sequence started on busy bus");
  mrs_addr_a: assert property ((sdram_cmd_out == `SRF_CMD_MRS) |-> (sdram_addr_out == r.mode_x))
    else $error("mode value not on address");

  // Request, arbitration and mode-write checks
  // Pending flag drops when a refresh sequence starts
  pend_start_a: assert property ((r.st == srf_pkg::S_IDLE) && (n.st == srf_pkg::S_PRECHARGE_ALL_CMD) &&
    (n.op == srf_pkg::OP_REF) && !match
    |=> !refresh_req_out)
    else $error("pending flag kept after start");

  // A second match while waiting still leaves one request
  pend_keep_a: assert property (match && refresh_req_out
    |=> refresh_req_out)
    else $error("repeated match lost the request");

  // Mode write follows precharge-all at once when no wait is set
  mrs_direct_a: assert property ((r.st == srf_pkg::S_PRECHARGE_ALL_CMD) && (r.op == srf_pkg::OP_MRS) && !r.precharge_wait_setting
    |=> (sdram_cmd_out == `SRF_CMD_MRS))
    else $error("mode write did not follow precharge-all");

  // One idle slot before the mode write when the wait is set
  mrs_wait_a: assert property ((r.st == srf_pkg::S_PRECHARGE_ALL_CMD) && (r.op == srf_pkg::OP_MRS) && r.precharge_wait_setting
    |=> (sdram_cmd_out == `SRF_CMD_NOP) ##1 (sdram_cmd_out == `SRF_CMD_MRS))
    else $error("mode write idle slot wrong");

  // Self-refresh entry: refresh command with clock enable low
  sref_entry_a: assert property ((r.st == srf_pkg::S_PRECHARGE_ALL_CMD) && (r.op == srf_pkg::OP_SREF) && !r.precharge_wait_setting
    |=> (sdram_cmd_out == `SRF_CMD_REF) && !sdram_cke_out
    && (r.st == srf_pkg::S_SREF))
    else $error("self-refresh entry wrong");

  // Auto-refresh starts only with enable set and mode select clear
  ref_enable_a: assert property ((r.st == srf_pkg::S_IDLE) && (n.st == srf_pkg::S_PRECHARGE_ALL_CMD) &&
    (n.op == srf_pkg::OP_REF) |-> r.rfen && !r.refresh_mode_select)
    else $error("refresh started while disabled");

  // No command while the memory sleeps
  sref_quiet_a: assert property ((r.st == srf_pkg::S_SREF)
    |=> (sdram_cmd_out == `SRF_CMD_NOP))
    else $error("command issued in self-refresh");

  // Clock enable is low only in self-refresh
  cke_low_a: assert property (!sdram_cke_out
    |-> (r.st == srf_pkg::S_SREF))
    else $error("clock enable low outside self-refresh");

  // Lockout ends when its count runs out
  lock_end_a: assert property ((r.st == srf_pkg::S_LOCK) && (r.lock == 4'h0)
    |=> (r.st == srf_pkg::S_IDLE))
    else $error("lockout did not end");

  // Manual reset raises no new request
  mrst_pend_a: assert property (manual_rst_in && !refresh_req_out
    |=> !refresh_req_out)
    else $error("request raised in manual reset");

  // Grant only rises while the sequencer is idle
  grant_busy_a: assert property (!bus_grant_out && (r.st != srf_pkg::S_IDLE)
    |=> !bus_grant_out)
    else $error("grant rose while busy");

  // Self-refresh holds until mode select is cleared, manual reset included
  sref_stay_a: assert property ((r.st == srf_pkg::S_SREF) && r.refresh_mode_select
    |=> (r.st == srf_pkg::S_SREF))
    else $error("self-refresh left early");

  // Pending refresh with enable set starts on a free bus
  auto_resume_a: assert property ((r.st == srf_pkg::S_IDLE) && refresh_req_out && r.rfen && !r.refresh_mode_select
    && !bus_busy_in && !bus_released_in && !bus_grant_out
    |=> (sdram_cmd_out == `SRF_CMD_PRECHARGE_ALL_CMD))
    else $error("auto-refresh did not resume");

  // Window write leaves a mode write pending
  win_pend_a: assert property (apb_wr && is_win
    |=> r.mrs_pend)
    else $error("window write not taken");

  // Counter steps by one on each selected tick
  tick_count_a: assert property (sel_tick(r.cks, r.presc) && !manual_rst_in && !match && !apb_wr
    |=> (r.cnt == $past(r.cnt) + 8'h01))
    else $error("counter did not step");

  // Self-refresh request wins on a free bus
  sref_prio_a: assert property ((r.st == srf_pkg::S_IDLE) && r.rfen && r.refresh_mode_select
    && !bus_busy_in && !bus_released_in && !bus_grant_out
    |=> (r.st == srf_pkg::S_PRECHARGE_ALL_CMD) && (r.op == srf_pkg::OP_SREF))
    else $error("self-refresh not started");

  // Main scenarios
  auto_ref_c: cover property ((r.st == srf_pkg::S_REF) ##1 (r.st == srf_pkg::S_LOCK));
  sref_c:     cover property ((r.st == srf_pkg::S_SREF) ##1 (r.st == srf_pkg::S_LOCK));
  mrs_c:      cover property ((r.st == srf_pkg::S_PWAIT) ##1 (r.st == srf_pkg::S_MRS));
  mrs_now_c:  cover property ((r.st == srf_pkg::S_PRECHARGE_ALL_CMD) ##1 (r.st == srf_pkg::S_MRS));
  freeze_c:   cover property (manual_rst_in && (r.cks != 3'h0) ##1 manual_rst_in);

endmodule

/* File: dv/srf_sdram_model.sv */
// Behavioural synchronous DRAM stand-in: counts refreshes and drives a changing data bus
`include "srf_cfg.svh"
module srf_sdram_model (
  // Clock
  input  wire logic        clk_in,
  // Command side
  input  wire logic [3:0]  cmd_in,
  input  wire logic        cke_in,
  // Data and observation
  output logic [15:0]      dq_out,
  output int               ref_cnt_out,
  output int               bad_cnt_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cke_prev = 1'b1;
  initial begin
    dq_out = 16'h0000;
    ref_cnt_out = 0;
    bad_cnt_out = 0;
  end
  // Bus never holds a stale value; any command while asleep is counted as bad
  always @(posedge clk_in) begin
    dq_out <= dq_out + 16'h1357;
    cke_prev <= cke_in;
    if (cmd_in === `SRF_CMD_REF) ref_cnt_out <= ref_cnt_out + 1;
    if (!cke_in && !cke_prev && cmd_in !== `SRF_CMD_NOP) bad_cnt_out <= bad_cnt_out + 1;
  end
endmodule

/* File: dv/srf_ctrl_tb.sv */
// Self-checking bench for the refresh and initialisation controller
`include "srf_cfg.svh"
module srf_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0, nrst_in = 1'b0, mrst = 1'b0, busy = 1'b0, rel = 1'b0, arb = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err_seen;
  logic        grant, rreq, hold, cke;
  logic [15:0] paddr = 16'h0000, dq, cap;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [3:0]  pstrb = 4'h0, cmd;
  logic [14:0] addr;
  int          errors = 0, check_count = 0, refs, bad, r0, n;
  logic [15:0] ra [5] = '{16'h0000, 16'h0008, 16'h000c, 16'h0004, 16'h0010};
  logic [31:0] rw [5] = '{32'h74, 32'h5a, 32'h33, 32'h0, 32'h12};
  logic [31:0] rx [5] = '{32'h74, 32'h5a, 32'h33, 32'h0, 32'h0};
  logic        re [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [15:0] mw [6] = '{16'h8426, 16'h8446, 16'h8466, 16'h8848, 16'h8888, 16'h88c8};

  always #25 clk_in = ~clk_in;

  srf_ctrl dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .manual_rst_in(mrst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .bus_busy_in(busy),
    .bus_released_in(rel), .bus_arb_req_in(arb), .bus_grant_out(grant), .refresh_req_out(rreq),
    .access_hold_out(hold), .sdram_dq_in(dq), .sdram_cmd_out(cmd), .sdram_cke_out(cke),
    .sdram_addr_out(addr), .rd_capture_out(cap));
  srf_sdram_model mdl_u (.clk_in(clk_in), .cmd_in(cmd), .cke_in(cke), .dq_out(dq),
    .ref_cnt_out(refs), .bad_cnt_out(bad));

  // Verdict and end of run
  task results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Compare seen against expected
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask
  // One APB transfer, waiting for pready under a bound
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      errors++;
      results;
    end
    rdata = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task rd(input logic [15:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  // Wait for a command at falling edges, bounded
  task wait_cmd(input logic [3:0] c);
    int k;
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (cmd !== c && k < 400);
    if (cmd !== c) begin
      errors++;
      results;
    end
  endtask
  // Precharge-all, optional wait, closing command, then quiet cycles
  task seq(input logic precharge_wait_setting, input logic [3:0] last, input int lock);
    wait_cmd(`SRF_CMD_PRECHARGE_ALL_CMD);
    chk(32'(addr[`SRF_A10_BIT]), 32'h1);
    if (precharge_wait_setting) begin
      @(negedge clk_in);
      chk(32'(cmd), 32'(`SRF_CMD_NOP));
    end
    @(negedge clk_in);
    chk(32'(cmd), 32'(last));
    repeat (lock) begin
      @(negedge clk_in);
      chk(32'(cmd), 32'(`SRF_CMD_NOP));
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    chk(32'({cmd, cke}), 32'h0f);
    nrst_in <= 1'b1;
    rd(16'h000c);
    chk(rdata, 32'hff);
    // Register table rows
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], rw[i]);
      chk(32'(err_seen), 32'(re[i]));
      rd(ra[i]);
      chk(rdata, rx[i]);
    end
    // Auto-refresh with short interval, counter preset one below compare
    wr(16'h0000, 32'h25);
    wr(16'h000c, 32'h3);
    wr(16'h0008, 32'h2);
    r0 = refs;
    wr(16'h0004, 32'h1);
    seq(1'b1, `SRF_CMD_REF, 4);
    for (n = 0; n < 2000 && refs - r0 < 8; n++) @(posedge clk_in);
    chk(32'(refs - r0 >= 8), 32'h1);
    // Requests held while the bus is busy, then released
    busy <= 1'b1;
    repeat (12) @(posedge clk_in);
    r0 = refs;
    repeat (30) @(posedge clk_in);
    busy <= 1'b0;
    rel <= 1'b1;
    wr(16'h0004, 32'h0);
    chk(32'(refs - r0), 32'h0);
    chk(32'(rreq), 32'h1);
    chk(32'(hold), 32'h1);
    rel <= 1'b0;
    repeat (40) @(posedge clk_in);
    chk(32'(refs - r0), 32'h1);
    // Mode register writes, both groups, both precharge waits
    repeat (2000) @(posedge clk_in);
    wr(16'h0000, 32'h0);
    for (int i = 0; i < 6; i++) begin
      if (i == 3) wr(16'h0000, 32'h4);
      apb(1'b1, mw[i], 32'hdead_beef, 4'h3);
      seq(i > 2, `SRF_CMD_MRS, 0);
      chk(32'(addr), 32'(mw[i][14:0]));
    end
    apb(1'b0, 16'h8426, 32'h0, 4'h0);
    chk(32'(err_seen), 32'h1);
    // Self-refresh with arbitration and manual reset
    wr(16'h0008, 32'h5);
    wr(16'h000c, 32'hff);
    wr(16'h0000, 32'h13);
    seq(1'b0, `SRF_CMD_REF, 0);
    chk(32'(cke), 32'h0);
    @(posedge clk_in);
    arb <= 1'b1;
    mrst <= 1'b1;
    wr(16'h0004, 32'h1);
    repeat (40) @(posedge clk_in);
    chk(32'({grant, cke}), 32'h0);
    rd(16'h0008);
    chk(rdata, 32'h5);
    mrst <= 1'b0;
    wr(16'h000c, 32'h6);
    wr(16'h0000, 32'h11);
    for (n = 0; n < 20 && cke !== 1'b1; n++) @(negedge clk_in);
    repeat (2) begin
      @(negedge clk_in);
      chk(32'({cke, cmd}), 32'h17);
    end
    for (n = 0; n < 20 && grant !== 1'b1; n++) @(posedge clk_in);
    chk(32'(grant), 32'h1);
    @(posedge clk_in);
    arb <= 1'b0;
    r0 = refs;
    repeat (80) @(posedge clk_in);
    chk(32'(refs > r0), 32'h1);
    wr(16'h0004, 32'h0);
    @(negedge clk_in);
    #1 chk(32'(cap), 32'(dq));
    // Power-on reset ends self-refresh
    wr(16'h0000, 32'h13);
    repeat (20) @(posedge clk_in);
    chk(32'(cke), 32'h0);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk(32'(cke), 32'h1);
    nrst_in <= 1'b1;
    rd(16'h0000);
    chk(rdata, 32'h0);
    chk(32'(hold), 32'h0);
    chk(32'(bad), 32'h0);
    results;
  end
endmodule
